// ### hdl/vcc_map.svh
// Register offsets, field positions, codes and reset values of the
// child-count and context leaf engine. Definitions only.
`ifndef VCC_MAP_SVH
`define VCC_MAP_SVH

`define VCC_OFS_CMD       8'h00
`define VCC_OFS_BASE      8'h04
`define VCC_OFS_COUNT     8'h08
`define VCC_OFS_DATA      8'h0C
`define VCC_OFS_CTXWORD   8'h10
`define VCC_OFS_ENV       8'h14
`define VCC_OFS_DSBASE    8'h18
`define VCC_OFS_DSLIMIT   8'h1C
`define VCC_OFS_RESULT    8'h20
`define VCC_OFS_ACCUM     8'h24
`define VCC_OFS_IRQSTAT   8'h28
`define VCC_OFS_IRQMASK   8'h2C
`define VCC_OFS_PAGESEL   8'h30
`define VCC_OFS_PAGECFG   8'h34
`define VCC_OFS_PAGECNT   8'h38
`define VCC_OFS_PAGECTX   8'h3C

`define VCC_LEAF_INC      8'h01
`define VCC_LEAF_CTX      8'h02
`define VCC_CMD_GO        8
`define VCC_ENV_CPL_HI    1
`define VCC_ENV_MODE64    2
`define VCC_ENV_DSUSABLE  3
`define VCC_ENV_FEATURE   5
`define VCC_CFG_VALID     0
`define VCC_CFG_BUSY      1
`define VCC_CFG_TYPE_LO   4
`define VCC_CFG_PAR_LO    8

`define VCC_TYPE_REGULAR        3'h0
`define VCC_TYPE_THREAD_CONTROL        3'h1
`define VCC_TYPE_TRIMMED       3'h2
`define VCC_TYPE_CONTROL_PAGE       3'h3

`define VCC_PAGES         8
`define VCC_PAGE_SHIFT    12
`define VCC_CACHE_BASE    32'h0010_0000
`define VCC_CACHE_TOP     32'h0010_8000
`define VCC_CONFLICT_CODE 32'h0000_0007
`define VCC_ENV_RESET     32'h0000_0028
`define VCC_LIMIT_RESET   32'hFFFF_FFFF
`define VCC_RES_BUSY      16

`endif

// ### hdl/vcc_pkg.sv
// Types shared by the child-count and context leaf engine.
// Assumes vcc_map.svh holds the numeric constants.
package vcc_pkg;

  typedef enum logic [1:0] {
    VCC_ST_IDLE = 2'b01,
    VCC_ST_EXEC = 2'b10
  } vcc_state_type;

  typedef enum logic [1:0] {
    VCC_FAULT_NONE = 2'h0,
    VCC_FAULT_GP   = 2'h1,
    VCC_FAULT_PF   = 2'h2,
    VCC_FAULT_UD   = 2'h3
  } vcc_fault_type;

endpackage

// ### hdl/vcc_leaf_engine.sv
// Leaf engine for the virtual child counter increment and context overwrite.
// Assumes one AHB-Lite master, single word transfers, one clock hclk.
// Functional notes
// (RULE_01) Leaf 01H with feature bit increments counter
// (RULE_02) Leaf 02H overwrites control page context value
// (RULE_03) Increment leaf runs only at privilege zero
// (RULE_04) Operand addresses use data segment, no override
// (RULE_05) Unaligned target page gives protection fault zero
// (RULE_06) Addresses outside page cache give page fault
// (RULE_07) Busy target sets zero flag, conflict code
// (RULE_08) Target taken shared; others run concurrently
// (RULE_09) Invalid target map entry gives page fault
// (RULE_10) Parent from page type; other types fault
// (RULE_11) Parent mismatch with control page: protection fault
// (RULE_12) Success increments counter, clears zero, returns 0
// (RULE_13) Zero only on conflict; other flags cleared
// (RULE_14) Segment, canonical or alignment faults: protection fault
// (RULE_15) Context leaf copies data word into control page
// (RULE_16) New control page context starts at own address
// (RULE_17) Context leaf fails misaligned or non-control page
// (RULE_18) Context leaf checks 4K and 8 byte alignment
// (RULE_19) Context leaf: zero only on conflict, clear others
`timescale 1ns/1ps
`include "vcc_map.svh"

module vcc_leaf_engine (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq
);
  import vcc_pkg::*;

  vcc_state_type   state_reg;
  vcc_fault_type   fault_reg;
  vcc_fault_type   fault_next;
  logic [7:0]      leaf_select_reg;
  logic [31:0]     base_reg;
  logic [31:0]     count_reg;
  logic [31:0]     data_reg;
  logic [31:0]     ctx_word_reg;
  logic [31:0]     env_reg;
  logic [31:0]     ds_base_reg;
  logic [31:0]     ds_limit_reg;
  logic [31:0]     accumulator_reg;
  logic [31:0]     accumulator_next;
  logic            zero_flag_reg;
  logic            zero_flag_next;
  logic [3:0]      irq_stat_reg;
  logic [3:0]      irq_mask_reg;
  logic [2:0]      page_sel_reg;
  logic            pg_valid  [`VCC_PAGES];
  logic            pg_busy   [`VCC_PAGES];
  logic [2:0]      pg_type   [`VCC_PAGES];
  logic [2:0]      pg_parent [`VCC_PAGES];
  logic [31:0]     pg_cnt    [`VCC_PAGES];
  logic [31:0]     pg_ctx    [`VCC_PAGES];
  logic            wr_pend_reg;
  logic            rd_pend_reg;
  logic            rd_wait_reg;
  logic [7:0]      addr_reg;
  logic            bus_wr;
  logic            go;
  logic            do_inc;
  logic            do_ctx;
  logic [2:0]      par_idx;
  logic [31:0]     lin_b;
  logic [31:0]     lin_c;
  logic [31:0]     lin_d;
  logic [2:0]      idx_b;
  logic [2:0]      idx_c;
  logic [3:0]      irq_set;

  // AHB-Lite slave: writes land in the data phase, reads take one wait state
  assign hresp     = 1'b0;
  // Low in the first read data phase cycle, while hrdata is being loaded
  assign hreadyout = ~(rd_pend_reg & ~rd_wait_reg);
  assign bus_wr    = wr_pend_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel & htrans[1] & hwrite;
      rd_pend_reg <= hsel & htrans[1] & ~hwrite;
      addr_reg    <= haddr[7:0];
    end else if (rd_wait_reg) begin
      rd_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_reg <= 1'b0;
      hrdata      <= 32'h0000_0000;
    end else begin
      rd_wait_reg <= rd_pend_reg & ~rd_wait_reg;
      if (rd_pend_reg & ~rd_wait_reg) begin
        case (addr_reg)
          `VCC_OFS_CMD:     hrdata <= {24'h00_0000, leaf_select_reg};
          `VCC_OFS_BASE:    hrdata <= base_reg;
          `VCC_OFS_COUNT:   hrdata <= count_reg;
          `VCC_OFS_DATA:    hrdata <= data_reg;
          `VCC_OFS_CTXWORD: hrdata <= ctx_word_reg;
          `VCC_OFS_ENV:     hrdata <= env_reg;
          `VCC_OFS_DSBASE:  hrdata <= ds_base_reg;
          `VCC_OFS_DSLIMIT: hrdata <= ds_limit_reg;
          `VCC_OFS_RESULT:  hrdata <= {15'h0000, (state_reg != VCC_ST_IDLE),
                                       6'h00, fault_reg, 7'h00, zero_flag_reg};
          `VCC_OFS_ACCUM:   hrdata <= accumulator_reg;
          `VCC_OFS_IRQSTAT: hrdata <= {28'h000_0000, irq_stat_reg};
          `VCC_OFS_IRQMASK: hrdata <= {28'h000_0000, irq_mask_reg};
          `VCC_OFS_PAGESEL: hrdata <= {29'h0000_0000, page_sel_reg};
          `VCC_OFS_PAGECFG: hrdata <= {21'h00_0000, pg_parent[page_sel_reg], 1'b0,
                                       pg_type[page_sel_reg], 2'h0,
                                       pg_busy[page_sel_reg], pg_valid[page_sel_reg]};
          `VCC_OFS_PAGECNT: hrdata <= pg_cnt[page_sel_reg];
          `VCC_OFS_PAGECTX: hrdata <= pg_ctx[page_sel_reg];
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Operand and environment registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leaf_select_reg <= 8'h00;
      base_reg        <= 32'h0000_0000;
      count_reg       <= 32'h0000_0000;
      data_reg        <= 32'h0000_0000;
      ctx_word_reg    <= 32'h0000_0000;
      env_reg         <= `VCC_ENV_RESET;
      ds_base_reg     <= 32'h0000_0000;
      ds_limit_reg    <= `VCC_LIMIT_RESET;
      irq_mask_reg    <= 4'h0;
      page_sel_reg    <= 3'h0;
    end else if (bus_wr) begin
      case (addr_reg)
        `VCC_OFS_CMD:     leaf_select_reg <= hwdata[7:0];
        `VCC_OFS_BASE:    base_reg        <= hwdata;
        `VCC_OFS_COUNT:   count_reg       <= hwdata;
        `VCC_OFS_DATA:    data_reg        <= hwdata;
        `VCC_OFS_CTXWORD: ctx_word_reg    <= hwdata;
        `VCC_OFS_ENV:     env_reg         <= hwdata;
        `VCC_OFS_DSBASE:  ds_base_reg     <= hwdata;
        `VCC_OFS_DSLIMIT: ds_limit_reg    <= hwdata;
        `VCC_OFS_IRQMASK: irq_mask_reg    <= hwdata[3:0];
        `VCC_OFS_PAGESEL: page_sel_reg    <= hwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  assign go = bus_wr && (addr_reg == `VCC_OFS_CMD) && hwdata[`VCC_CMD_GO] &&
              (state_reg == VCC_ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= VCC_ST_IDLE;
    end else begin
      case (state_reg)
        VCC_ST_IDLE: begin
          if (go) begin
            state_reg <= VCC_ST_EXEC;
          end
        end
        VCC_ST_EXEC: state_reg <= VCC_ST_IDLE;
        default:     state_reg <= VCC_ST_IDLE;
      endcase
    end
  end

  // Linear addresses always from the data segment
  assign lin_b = ds_base_reg + base_reg; // RULE_04
  assign lin_c = ds_base_reg + count_reg; // RULE_04
  assign lin_d = ds_base_reg + data_reg; // RULE_04
  assign idx_b = lin_b[`VCC_PAGE_SHIFT+2:`VCC_PAGE_SHIFT];
  assign idx_c = lin_c[`VCC_PAGE_SHIFT+2:`VCC_PAGE_SHIFT];

  function automatic logic in_cache(input logic [31:0] a);
    in_cache = (a >= `VCC_CACHE_BASE) && (a < `VCC_CACHE_TOP);
  endfunction

  function automatic logic seg_bad(input logic [31:0] ofs, input logic [31:0] lin,
                                   input logic [31:0] env, input logic [31:0] lim);
    if (env[`VCC_ENV_MODE64]) begin
      seg_bad = (lin[31] != lin[30]);
    end else begin
      seg_bad = !env[`VCC_ENV_DSUSABLE] || (ofs > lim);
    end
  endfunction

  // Leaf checks in documented order; first failing check decides
  always_comb begin
    fault_next       = VCC_FAULT_NONE;
    zero_flag_next   = 1'b0;
    accumulator_next = accumulator_reg;
    do_inc           = 1'b0;
    do_ctx           = 1'b0;
    par_idx          = idx_b;
    if (!env_reg[`VCC_ENV_FEATURE]) begin
      fault_next = VCC_FAULT_UD;
    end else if (leaf_select_reg == `VCC_LEAF_INC) begin // RULE_01
      if (env_reg[`VCC_ENV_CPL_HI:0] != 2'h0) begin
        fault_next = VCC_FAULT_GP; // RULE_03
      end else if (seg_bad(base_reg, lin_b, env_reg, ds_limit_reg) ||
                   seg_bad(count_reg, lin_c, env_reg, ds_limit_reg)) begin
        fault_next = VCC_FAULT_GP; // RULE_14
      end else if (lin_b[`VCC_PAGE_SHIFT-1:0] != 12'h000) begin
        fault_next = VCC_FAULT_GP; // RULE_05
      end else if (!in_cache(lin_b) || !in_cache(lin_c)) begin
        fault_next = VCC_FAULT_PF; // RULE_06
      end else if (pg_busy[idx_b]) begin
        zero_flag_next   = 1'b1; // RULE_07 RULE_08
        accumulator_next = `VCC_CONFLICT_CODE; // RULE_07
      end else if (!pg_valid[idx_b]) begin
        fault_next = VCC_FAULT_PF; // RULE_09
      end else begin
        case (pg_type[idx_b])
          `VCC_TYPE_REGULAR, `VCC_TYPE_THREAD_CONTROL, `VCC_TYPE_TRIMMED: par_idx = pg_parent[idx_b]; // RULE_10
          `VCC_TYPE_CONTROL_PAGE: par_idx = idx_b; // RULE_10
          default:      fault_next = VCC_FAULT_PF; // RULE_10
        endcase
        if (fault_next == VCC_FAULT_NONE) begin
          if (par_idx != idx_c || lin_c[`VCC_PAGE_SHIFT-1:0] != 12'h000) begin
            fault_next = VCC_FAULT_GP; // RULE_11
          end else begin
            do_inc           = 1'b1; // RULE_12
            accumulator_next = 32'h0000_0000; // RULE_12
          end
        end
      end
    end else if (leaf_select_reg == `VCC_LEAF_CTX) begin // RULE_02
      if (env_reg[`VCC_ENV_CPL_HI:0] != 2'h0) begin
        fault_next = VCC_FAULT_GP;
      end else if (seg_bad(count_reg, lin_c, env_reg, ds_limit_reg) ||
                   seg_bad(data_reg, lin_d, env_reg, ds_limit_reg)) begin
        fault_next = VCC_FAULT_GP; // RULE_14
      end else if (lin_c[`VCC_PAGE_SHIFT-1:0] != 12'h000) begin
        fault_next = VCC_FAULT_GP; // RULE_18 RULE_17
      end else if (!in_cache(lin_c)) begin
        fault_next = VCC_FAULT_PF; // RULE_06
      end else if (lin_d[2:0] != 3'h0) begin
        fault_next = VCC_FAULT_GP; // RULE_18 RULE_17
      end else if (pg_busy[idx_c]) begin
        zero_flag_next   = 1'b1; // RULE_19
        accumulator_next = `VCC_CONFLICT_CODE;
      end else if (!pg_valid[idx_c] || pg_type[idx_c] != `VCC_TYPE_CONTROL_PAGE) begin
        fault_next = VCC_FAULT_PF; // RULE_17
      end else begin
        do_ctx           = 1'b1; // RULE_15
        accumulator_next = 32'h0000_0000;
      end
    end else begin
      fault_next = VCC_FAULT_UD;
    end
  end

  // Result: zero flag only from a conflict, arithmetic flags read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_reg       <= VCC_FAULT_NONE;
      zero_flag_reg   <= 1'b0;
      accumulator_reg <= 32'h0000_0000;
    end else if (state_reg == VCC_ST_EXEC) begin
      fault_reg <= fault_next;
      if (fault_next == VCC_FAULT_NONE) begin
        zero_flag_reg   <= zero_flag_next; // RULE_13 RULE_19
        accumulator_reg <= accumulator_next;
      end
    end
  end

  // Page cache map and control page fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `VCC_PAGES; i++) begin
        pg_valid[i]  <= 1'b0;
        pg_busy[i]   <= 1'b0;
        pg_type[i]   <= `VCC_TYPE_REGULAR;
        pg_parent[i] <= 3'h0;
        pg_cnt[i]    <= 32'h0000_0000;
        pg_ctx[i]    <= 32'h0000_0000;
      end
    end else begin
      if (state_reg == VCC_ST_EXEC && do_inc) begin
        pg_cnt[par_idx] <= pg_cnt[par_idx] + 32'h0000_0001; // RULE_12
      end
      if (state_reg == VCC_ST_EXEC && do_ctx) begin
        pg_ctx[idx_c] <= ctx_word_reg; // RULE_15
      end
      if (bus_wr && addr_reg == `VCC_OFS_PAGECFG) begin
        pg_valid[page_sel_reg]  <= hwdata[`VCC_CFG_VALID];
        pg_busy[page_sel_reg]   <= hwdata[`VCC_CFG_BUSY];
        pg_type[page_sel_reg]   <= hwdata[`VCC_CFG_TYPE_LO+2:`VCC_CFG_TYPE_LO];
        pg_parent[page_sel_reg] <= hwdata[`VCC_CFG_PAR_LO+2:`VCC_CFG_PAR_LO];
        if (hwdata[`VCC_CFG_VALID] &&
            hwdata[`VCC_CFG_TYPE_LO+2:`VCC_CFG_TYPE_LO] == `VCC_TYPE_CONTROL_PAGE) begin
          pg_ctx[page_sel_reg] <= `VCC_CACHE_BASE + {17'h0_0000, page_sel_reg, 12'h000}; // RULE_16
          pg_cnt[page_sel_reg] <= 32'h0000_0000;
        end
      end
    end
  end

  // Interrupt status: done, protection fault, page fault, conflict
  assign irq_set = (state_reg == VCC_ST_EXEC) ?
                   {(fault_next == VCC_FAULT_NONE) && zero_flag_next,
                    fault_next == VCC_FAULT_PF,
                    fault_next == VCC_FAULT_GP,
                    1'b1} : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= 4'h0;
    end else if (bus_wr && addr_reg == `VCC_OFS_IRQSTAT) begin
      irq_stat_reg <= (irq_stat_reg & ~hwdata[3:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

// ### verif/vcc_leaf_engine_monitor.sv
// Concurrent checks on the bus and interrupt ports of the leaf engine.
// Assumes one clock hclk and the zero-wait write, one-wait read slave timing.
`timescale 1ns/1ps
`include "vcc_map.svh"

module vcc_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        irq
);
  logic        rd_taken;
  logic        wr_taken;
  logic        wr_dat_reg;
  logic [7:0]  wr_ofs_reg;
  logic [31:0] mask_reg;
  logic        go_dat;
  logic        mask_dat;
  logic        stat_dat;

  assign rd_taken = hsel && htrans[1] && hready && !hwrite;
  assign wr_taken = hsel && htrans[1] && hready && hwrite;
  assign go_dat   = wr_dat_reg && (wr_ofs_reg == `VCC_OFS_CMD) && hwdata[`VCC_CMD_GO];
  assign mask_dat = wr_dat_reg && (wr_ofs_reg == `VCC_OFS_IRQMASK);
  assign stat_dat = wr_dat_reg && (wr_ofs_reg == `VCC_OFS_IRQSTAT);

  // Tracks the write data phase and the mask that software last wrote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dat_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      mask_reg   <= 32'h0000_0000;
    end else if (hready) begin
      wr_dat_reg <= wr_taken;
      wr_ofs_reg <= haddr[7:0];
      if (mask_dat) begin
        mask_reg <= hwdata;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_addr;
    rd_taken;
  endsequence

  sequence s_wait_once;
    !hreadyout ##1 hreadyout;
  endsequence

  a_resp_always_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  a_write_no_wait: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stretched");
  a_read_one_wait: assert property (s_rd_addr |=> s_wait_once)
    else $error("read data phase not exactly one wait");
  a_wait_has_read: assert property (!hreadyout |-> $past(rd_taken))
    else $error("wait state without a read");
  a_rdata_only_read: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data changed outside a read");
  a_irq_needs_mask: assert property (irq |-> mask_reg[3:0] != 4'h0)
    else $error("interrupt with all sources masked");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(go_dat, 2) || $past(mask_dat))
    else $error("interrupt rose without leaf or mask write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(stat_dat) || $past(mask_dat))
    else $error("interrupt fell without clear or mask write");
endmodule

bind vcc_leaf_engine vcc_monitor u_mon (
  .hclk      (hclk),
  .hresetn   (hresetn),
  .hsel      (hsel),
  .haddr     (haddr),
  .htrans    (htrans),
  .hwrite    (hwrite),
  .hsize     (hsize),
  .hwdata    (hwdata),
  .hready    (hready),
  .hreadyout (hreadyout),
  .hrdata    (hrdata),
  .hresp     (hresp),
  .irq       (irq)
);

// ### verif/vcc_leaf_engine_bench.sv
// Self-checking bench for the leaf engine, driving its AHB-Lite port.
// Assumes the engine is the only slave, so hready is its own hreadyout.
`timescale 1ns/1ps
`include "vcc_map.svh"

module vcc_leaf_engine_bench;
  import vcc_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] last_acc;
  logic        last_zf;
  logic [31:0] cfg [8];
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;

  vcc_leaf_engine uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test;
    end
  end

  function automatic logic [31:0] pg(input int i);
    return `VCC_CACHE_BASE + (32'(i) << `VCC_PAGE_SHIFT);
  endfunction

  task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d,
                           output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    bus_cycle(a, 1'b1, d, rd);
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus_cycle(a, 1'b0, 32'h0, rd);
    compare(name, exp, rd);
  endtask

  task automatic run_leaf(input logic [7:0] l, input logic [31:0] b, input logic [31:0] c,
                          input logic [31:0] d, input vcc_fault_type f, input logic z);
    bus_write(`VCC_OFS_BASE, b);
    bus_write(`VCC_OFS_COUNT, c);
    bus_write(`VCC_OFS_DATA, d);
    bus_write(`VCC_OFS_CMD, {23'h0, 1'b1, l});
    do bus_cycle(`VCC_OFS_RESULT, 1'b0, 32'h0, rd); while (rd[`VCC_RES_BUSY] !== 1'b0);
    // A fault leaves zero flag and accumulator as they were
    if (f == VCC_FAULT_NONE) begin
      last_zf  = z;
      last_acc = z ? `VCC_CONFLICT_CODE : 32'h0;
    end
    compare("result", {22'h0, f, 2'h0, 5'h0, last_zf}, {22'h0, rd[9:8], 2'h0, rd[5:0]});
    read_check(`VCC_OFS_ACCUM, last_acc, "accumulator");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    last_zf = 1'b0;
    last_acc = 32'h0;
    cfg = '{32'h31, 32'h01, 32'h11, 32'h21, 32'h51, 32'h03, 32'h00, 32'h31};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    read_check(`VCC_OFS_ENV, `VCC_ENV_RESET, "env reset");
    read_check(`VCC_OFS_DSLIMIT, `VCC_LIMIT_RESET, "limit reset");
    bus_write(8'h40, 32'h1234_5678);
    read_check(8'h40, 32'h0, "unmapped");
    bus_write(`VCC_OFS_DSBASE, 32'h0);
    // Pages: control, regular, thread, trimmed, bad type, busy, absent, control
    for (int i = 0; i < 8; i++) begin
      bus_write(`VCC_OFS_PAGESEL, i);
      bus_write(`VCC_OFS_PAGECFG, cfg[i]);
    end
    bus_write(`VCC_OFS_PAGESEL, 32'h0);
    read_check(`VCC_OFS_PAGECTX, pg(0), "initial context");
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_NONE, 1'b0);
    compare("irq masked", 32'h0, {31'h0, irq});
    bus_write(`VCC_OFS_IRQMASK, 32'h1);
    read_check(`VCC_OFS_IRQSTAT, 32'h1, "done status");
    compare("irq raised", 32'h1, {31'h0, irq});
    bus_write(`VCC_OFS_IRQSTAT, 32'hF);
    read_check(`VCC_OFS_IRQSTAT, 32'h0, "cleared status");
    compare("irq cleared", 32'h0, {31'h0, irq});
    bus_write(`VCC_OFS_IRQMASK, 32'h2);
    run_leaf(8'h01, pg(0) + 32'h8, pg(0), 0, VCC_FAULT_GP, 1'b0);
    compare("irq protection", 32'h1, {31'h0, irq});
    bus_write(`VCC_OFS_IRQSTAT, 32'hF);
    run_leaf(8'h01, pg(2), pg(0), 0, VCC_FAULT_NONE, 1'b0);
    run_leaf(8'h01, pg(3), pg(0), 0, VCC_FAULT_NONE, 1'b0);
    run_leaf(8'h01, pg(0), pg(0), 0, VCC_FAULT_NONE, 1'b0);
    run_leaf(8'h01, 32'h0020_0000, pg(0), 0, VCC_FAULT_PF, 1'b0);
    run_leaf(8'h01, pg(1), 32'h0030_0000, 0, VCC_FAULT_PF, 1'b0);
    run_leaf(8'h01, pg(5), pg(0), 0, VCC_FAULT_NONE, 1'b1);
    run_leaf(8'h01, pg(6), pg(0), 0, VCC_FAULT_PF, 1'b0);
    run_leaf(8'h01, pg(4), pg(0), 0, VCC_FAULT_PF, 1'b0);
    run_leaf(8'h01, pg(1), pg(7), 0, VCC_FAULT_GP, 1'b0);
    run_leaf(8'h03, pg(1), pg(0), 0, VCC_FAULT_UD, 1'b0);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_NONE, 1'b0);
    bus_write(`VCC_OFS_ENV, 32'h08);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_UD, 1'b0);
    bus_write(`VCC_OFS_ENV, 32'h29);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_GP, 1'b0);
    bus_write(`VCC_OFS_ENV, 32'h20);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_GP, 1'b0);
    bus_write(`VCC_OFS_ENV, 32'h28);
    bus_write(`VCC_OFS_DSLIMIT, 32'h000F_FFFF);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_GP, 1'b0);
    bus_write(`VCC_OFS_DSLIMIT, `VCC_LIMIT_RESET);
    bus_write(`VCC_OFS_ENV, 32'h2C);
    bus_write(`VCC_OFS_DSBASE, 32'h4000_0000);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_GP, 1'b0);
    bus_write(`VCC_OFS_DSBASE, pg(0));
    run_leaf(8'h01, 32'h1000, 32'h0, 0, VCC_FAULT_NONE, 1'b0);
    bus_write(`VCC_OFS_DSBASE, 32'h0);
    bus_write(`VCC_OFS_ENV, 32'h28);
    read_check(`VCC_OFS_PAGECNT, 32'h6, "counter");
    bus_write(`VCC_OFS_CTXWORD, 32'hCAFE_0000);
    run_leaf(8'h02, 0, pg(7), 32'h8, VCC_FAULT_NONE, 1'b0);
    bus_write(`VCC_OFS_PAGESEL, 32'h7);
    read_check(`VCC_OFS_PAGECTX, 32'hCAFE_0000, "context");
    read_check(`VCC_OFS_PAGECNT, 32'h0, "other counter");
    run_leaf(8'h02, 0, pg(7), 32'h4, VCC_FAULT_GP, 1'b0);
    run_leaf(8'h02, 0, pg(7) + 32'h10, 32'h8, VCC_FAULT_GP, 1'b0);
    run_leaf(8'h02, 0, pg(1), 32'h8, VCC_FAULT_PF, 1'b0);
    run_leaf(8'h02, 0, 32'h0030_0000, 32'h8, VCC_FAULT_PF, 1'b0);
    bus_write(`VCC_OFS_PAGECFG, 32'h33);
    run_leaf(8'h02, 0, pg(7), 32'h8, VCC_FAULT_NONE, 1'b1);
    bus_write(`VCC_OFS_PAGESEL, 32'h0);
    bus_write(`VCC_OFS_PAGECFG, 32'h33);
    run_leaf(8'h01, pg(1), pg(0), 0, VCC_FAULT_NONE, 1'b0);
    read_check(`VCC_OFS_PAGECNT, 32'h1, "counter after reload");
    stop_test;
  end
endmodule
